// ### common/dspsc_pkg.sv
// Purpose: Shared constants and types for the dual serial port slave config
// Assumes: 100 MHz core clock, Avalon-MM byte addresses
// Notes: Port register blocks sit at a 0x20 stride
package dspsc_pkg;
  localparam int NPORT = 2;
  localparam int CLK_NS = 10;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
  // Register map
  localparam logic [6:0] OFF_ADDR = 7'h00;
  localparam logic [6:0] OFF_CTRL = 7'h04;
  localparam logic [6:0] OFF_CUSTOM = 7'h08;
  localparam logic [6:0] OFF_DELAY = 7'h0C;
  localparam logic [6:0] OFF_TMO = 7'h10;
  localparam logic [6:0] OFF_STATE = 7'h14;
  localparam logic [6:0] OFF_STATUS = 7'h40;
  localparam logic [6:0] OFF_MASK = 7'h44;
  localparam int PORT_BIT = 5;
  localparam int GLOBAL_BIT = 6;
  // Control register fields
  localparam int CTRL_POWERON = 0;
  localparam int CTRL_BAUD_LO = 1;
  localparam int CTRL_CUSTOM = 4;
  localparam int CTRL_DATA8 = 5;
  localparam int CTRL_PAR_LO = 6;
  localparam int CTRL_STOP2 = 8;
  localparam int CTRL_RTU = 9;
  // Status bits per port
  localparam int ST_ACCEPT = 0;
  localparam int ST_TIMEOUT = 1;
  // Reset values and ranges
  localparam logic [7:0] ADDR_RST = 8'h01;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hFE;
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [2:0] BAUD_RST = 3'h3;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [12:0] CUSTOM_RST = 13'h0060;
  localparam logic [12:0] CUSTOM_MIN = 13'h0001;
  localparam logic [12:0] CUSTOM_MAX = 13'h1388;
  localparam logic [11:0] DELAY_RST = 12'h000;
  localparam logic [11:0] TMO_RST = 12'h0C8;
  localparam logic [11:0] MS_MAX = 12'hBB8;
  // Standard rates in 100 bps units, 1200 to 115200
  localparam logic [12:0] RATE_TAB [8] = '{13'h000C, 13'h0018, 13'h0030, 13'h0060,
                                           13'h00C0, 13'h0180, 13'h0240, 13'h0480};

  typedef struct packed {
    logic [7:0] addr;
    logic poweron;
    logic [2:0] baud_sel;
    logic custom_en;
    logic data8;
    logic [1:0] parity;
    logic stop2;
    logic rtu;
    logic [12:0] custom;
    logic [11:0] delay;
    logic [11:0] tmo;
  } dspsc_cfg_type;

  localparam dspsc_cfg_type CFG_RST = '{ADDR_RST, 1'b0, BAUD_RST, 1'b0, 1'b0, PAR_EVEN,
                                       1'b0, 1'b0, CUSTOM_RST, DELAY_RST, TMO_RST};

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
  } dspsc_frame_type;

  typedef struct packed {
    logic active;
    logic accept;
    logic reply_go;
    logic rx_timeout;
    logic [12:0] rate;
    logic data8;
    logic [1:0] parity;
    logic stop2;
    logic rtu;
  } dspsc_port_out_type;

  typedef enum logic [1:0] {ST_IDLE, ST_REPLY, ST_RESP} dspsc_state_type;
endpackage

// ### src/dspsc_top.sv
// Purpose: Two independent serial port configurations with station filter and timers
// Assumes: Run level, frames and transaction strobes come from core-clock logic
// Notes: Registers over Avalon-MM, one wait cycle per access
//
// Functional notes
// - Two ports, fully independent settings
// - Station address 1..254, default 1
// - Station zero frame accepted as broadcast
// - Default start on stop-to-run change
// - Power-on option starts at once
// - Standard rate list, default 9600, or custom
// - Framing per port, default 7E1 ASCII
// - Reply delay 0..3000 ms before response
// - Receive timeout 0..3000 ms, default 200
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
module dspsc_top #(
  parameter int P_TICK_CYC = dspsc_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [6:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Controller run state
  input wire logic i_plc_run,
  // Per-port traffic events
  input wire dspsc_pkg::dspsc_frame_type i_rx_frame [dspsc_pkg::NPORT],
  input wire logic [dspsc_pkg::NPORT-1:0] i_req_sent,
  input wire logic [dspsc_pkg::NPORT-1:0] i_resp_got,
  // Per-port results and interrupt
  output dspsc_pkg::dspsc_port_out_type o_port [dspsc_pkg::NPORT],
  output logic o_irq
);

  localparam int NP = dspsc_pkg::NPORT;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Bus access timing

  logic wait_q, wait_d;
  logic acc, wr_en;
  logic [31:0] rdata_d;
  logic run_q;

  assign acc = (i_avs_read || i_avs_write) && !wait_q;
  assign wr_en = i_avs_write && !wait_q;

  always_comb begin
    wait_d = 1'b1;
    if ((i_avs_read || i_avs_write) && wait_q) begin
      wait_d = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wait_q <= 1'b1;
      run_q <= 1'b0;
    end else begin
      wait_q <= wait_d;
      run_q <= i_plc_run;
    end
  end

  assign o_avs_waitrequest = wait_q;

  ////////////////////////////////////////////////////////////////////////////
  // Per-port configuration and timers

  dspsc_pkg::dspsc_cfg_type cfg_q [NP];
  dspsc_pkg::dspsc_port_out_type out_q [NP];
  logic [2*NP-1:0] evt;
  logic [31:0] port_rd [NP];

  for (genvar p = 0; p < NP; p++) begin : g_port
    dspsc_pkg::dspsc_cfg_type cfg_d;
    dspsc_pkg::dspsc_port_out_type out_d;
    dspsc_pkg::dspsc_state_type st_q, st_d;
    logic [16:0] tick_q, tick_d;
    logic [11:0] ms_q, ms_d;
    logic sel, hit, adv;
    logic [6:0] off;

    assign sel = wr_en && !i_avs_address[dspsc_pkg::GLOBAL_BIT]
                 && (i_avs_address[dspsc_pkg::PORT_BIT] == 1'(p));
    assign off = {2'b00, i_avs_address[4:0]};
    assign hit = i_rx_frame[p].valid && (i_rx_frame[p].addr == dspsc_pkg::ADDR_BCAST
                 || i_rx_frame[p].addr == cfg_q[p].addr);
    assign adv = (tick_q == 17'(P_TICK_CYC - 1));

    always_comb begin
      cfg_d = cfg_q[p];
      if (sel) begin
        case (off)
          dspsc_pkg::OFF_ADDR: begin
            if (i_avs_writedata[7:0] >= dspsc_pkg::ADDR_MIN
                && i_avs_writedata[7:0] <= dspsc_pkg::ADDR_MAX) begin
              cfg_d.addr = i_avs_writedata[7:0];
            end
          end
          dspsc_pkg::OFF_CTRL: begin
            cfg_d.poweron = i_avs_writedata[dspsc_pkg::CTRL_POWERON];
            cfg_d.baud_sel = i_avs_writedata[dspsc_pkg::CTRL_BAUD_LO +: 3];
            cfg_d.custom_en = i_avs_writedata[dspsc_pkg::CTRL_CUSTOM];
            cfg_d.data8 = i_avs_writedata[dspsc_pkg::CTRL_DATA8];
            cfg_d.parity = i_avs_writedata[dspsc_pkg::CTRL_PAR_LO +: 2];
            cfg_d.stop2 = i_avs_writedata[dspsc_pkg::CTRL_STOP2];
            cfg_d.rtu = i_avs_writedata[dspsc_pkg::CTRL_RTU];
          end
          dspsc_pkg::OFF_CUSTOM: begin
            if (i_avs_writedata[12:0] >= dspsc_pkg::CUSTOM_MIN
                && i_avs_writedata[12:0] <= dspsc_pkg::CUSTOM_MAX
                && i_avs_writedata[31:13] == 19'h0_0000) begin
              cfg_d.custom = i_avs_writedata[12:0];
            end
          end
          dspsc_pkg::OFF_DELAY: begin
            if (i_avs_writedata[11:0] <= dspsc_pkg::MS_MAX
                && i_avs_writedata[31:12] == 20'h0_0000) begin
              cfg_d.delay = i_avs_writedata[11:0];
            end
          end
          dspsc_pkg::OFF_TMO: begin
            if (i_avs_writedata[11:0] <= dspsc_pkg::MS_MAX
                && i_avs_writedata[31:12] == 20'h0_0000) begin
              cfg_d.tmo = i_avs_writedata[11:0];
            end
          end
          default: begin
          end
        endcase
      end
    end

    always_comb begin
      out_d = out_q[p];
      out_d.accept = 1'b0;
      out_d.reply_go = 1'b0;
      out_d.rx_timeout = 1'b0;
      st_d = st_q;
      tick_d = adv ? 17'h0_0000 : tick_q + 17'h0_0001;
      ms_d = adv ? ms_q + 12'h001 : ms_q;
      if (cfg_q[p].poweron) begin
        out_d.active = 1'b1;
      end else if (i_plc_run && !run_q) begin
        out_d.active = 1'b1;
      end else if (!i_plc_run) begin
        out_d.active = 1'b0;
      end
      out_d.rate = cfg_q[p].custom_en ? cfg_q[p].custom
                                       : dspsc_pkg::RATE_TAB[cfg_q[p].baud_sel];
      out_d.data8 = cfg_q[p].data8;
      out_d.parity = cfg_q[p].parity;
      out_d.stop2 = cfg_q[p].stop2;
      out_d.rtu = cfg_q[p].rtu;
      case (st_q)
        dspsc_pkg::ST_IDLE: begin
          tick_d = 17'h0_0000;
          ms_d = 12'h000;
          if (out_q[p].active && hit) begin
            out_d.accept = 1'b1;
            st_d = dspsc_pkg::ST_REPLY;
          end else if (out_q[p].active && i_req_sent[p]) begin
            st_d = dspsc_pkg::ST_RESP;
          end
        end
        dspsc_pkg::ST_REPLY: begin
          if (ms_q == cfg_q[p].delay) begin
            out_d.reply_go = 1'b1;
            st_d = dspsc_pkg::ST_IDLE;
          end
        end
        dspsc_pkg::ST_RESP: begin
          if (i_resp_got[p]) begin
            st_d = dspsc_pkg::ST_IDLE;
          end else if (cfg_q[p].tmo != 12'h000 && ms_q == cfg_q[p].tmo) begin
            out_d.rx_timeout = 1'b1;
            st_d = dspsc_pkg::ST_IDLE;
          end
        end
        default: begin
          st_d = dspsc_pkg::ST_IDLE;
        end
      endcase
      if (!out_q[p].active) begin
        st_d = dspsc_pkg::ST_IDLE;
      end
    end

    always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
        cfg_q[p] <= dspsc_pkg::CFG_RST;
        out_q[p] <= '0;
        st_q <= dspsc_pkg::ST_IDLE;
        tick_q <= 17'h0_0000;
        ms_q <= 12'h000;
      end else begin
        cfg_q[p] <= cfg_d;
        out_q[p] <= out_d;
        st_q <= st_d;
        tick_q <= tick_d;
        ms_q <= ms_d;
      end
    end

    assign evt[2*p+dspsc_pkg::ST_ACCEPT] = out_d.accept;
    assign evt[2*p+dspsc_pkg::ST_TIMEOUT] = out_d.rx_timeout;
    assign o_port[p] = out_q[p];
    assign port_rd[p] = (off == dspsc_pkg::OFF_ADDR) ? {24'h00_0000, cfg_q[p].addr} :
      (off == dspsc_pkg::OFF_CTRL) ? {22'h00_0000, cfg_q[p].rtu, cfg_q[p].stop2,
        cfg_q[p].parity, cfg_q[p].data8, cfg_q[p].custom_en, cfg_q[p].baud_sel,
        cfg_q[p].poweron} :
      (off == dspsc_pkg::OFF_CUSTOM) ? {19'h0_0000, cfg_q[p].custom} :
      (off == dspsc_pkg::OFF_DELAY) ? {20'h0_0000, cfg_q[p].delay} :
      (off == dspsc_pkg::OFF_TMO) ? {20'h0_0000, cfg_q[p].tmo} :
      (off == dspsc_pkg::OFF_STATE) ? {29'h0000_0000, st_q, out_q[p].active} : 32'h0000_0000;

    AST_PORT_INDEP: assert property (wr_en && i_avs_address[dspsc_pkg::PORT_BIT] != 1'(p)
      |=> $stable(cfg_q[p])) else $error("write altered other port");
    AST_ADDR_RANGE: assert property (cfg_q[p].addr >= dspsc_pkg::ADDR_MIN
      && cfg_q[p].addr <= dspsc_pkg::ADDR_MAX) else $error("station address out of range");
    AST_BCAST: assert property (out_q[p].active && st_q == dspsc_pkg::ST_IDLE
      && i_rx_frame[p].valid && i_rx_frame[p].addr == dspsc_pkg::ADDR_BCAST
      |=> out_q[p].accept) else $error("broadcast frame not accepted");
    AST_STOP_IDLE: assert property (!cfg_q[p].poweron && !i_plc_run |=> !out_q[p].active)
      else $error("port active while stopped");
    AST_POWERON: assert property (cfg_q[p].poweron |=> out_q[p].active)
      else $error("power-on port not active");
    // Rate follows selection, skipped on the first edge out of reset
    AST_RATE: assert property (!$past(i_rst)
      |-> out_q[p].rate == ($past(cfg_q[p].custom_en)
      ? $past(cfg_q[p].custom) : dspsc_pkg::RATE_TAB[$past(cfg_q[p].baud_sel)]))
      else $error("rate mismatch");
    AST_CUSTOM: assert property (cfg_q[p].custom >= dspsc_pkg::CUSTOM_MIN
      && cfg_q[p].custom <= dspsc_pkg::CUSTOM_MAX) else $error("custom rate out of range");
    AST_NODELAY: assert property (out_q[p].accept && cfg_q[p].delay == 12'h000
      && out_q[p].active |=> out_q[p].reply_go) else $error("zero delay reply late");
    AST_TMO_OFF: assert property (cfg_q[p].tmo == 12'h000 |=> !out_q[p].rx_timeout)
      else $error("timeout with zero setting");
    AST_TICK: assert property (tick_q < 17'(P_TICK_CYC))
      else $error("tick counter overrun");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and read data

  logic [2*NP-1:0] status_q, status_d, mask_q, mask_d;
  logic irq_q, irq_d;
  logic [31:0] rdata_q;

  always_comb begin
    status_d = status_q;
    mask_d = mask_q;
    if (wr_en && i_avs_address == dspsc_pkg::OFF_STATUS) begin
      status_d = status_q & ~i_avs_writedata[2*NP-1:0];
    end
    if (wr_en && i_avs_address == dspsc_pkg::OFF_MASK) begin
      mask_d = i_avs_writedata[2*NP-1:0];
    end
    // Events win over a same-cycle clear
    status_d = status_d | evt;
    irq_d = |(status_d & mask_d);
    rdata_d = 32'h0000_0000;
    if (i_avs_read && wait_q) begin
      if (!i_avs_address[dspsc_pkg::GLOBAL_BIT]) begin
        rdata_d = port_rd[i_avs_address[dspsc_pkg::PORT_BIT]];
      end else if (i_avs_address == dspsc_pkg::OFF_STATUS) begin
        rdata_d = {28'h000_0000, status_q};
      end else if (i_avs_address == dspsc_pkg::OFF_MASK) begin
        rdata_d = {28'h000_0000, mask_q};
      end
    end else if (acc) begin
      rdata_d = rdata_q;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      status_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_irq = irq_q;
  assign o_avs_readdata = rdata_q;

  AST_IRQ: assert property (##1 o_irq == |(status_q & mask_q))
    else $error("irq does not follow status and mask");
  AST_WAIT: assert property (!wait_q |=> wait_q) else $error("waitrequest low twice");

endmodule

// ### bench/dspsc_remote_master.sv
// Purpose: Remote serial master driving port events
// Assumes: Pulses launched by NBA after a rising edge
// Notes: Idle address shows the inverse of the last one
module dspsc_remote_master (
  // Clock
  input wire logic i_core_clk,
  // Events toward the ports
  output dspsc_pkg::dspsc_frame_type o_rx_frame [dspsc_pkg::NPORT],
  output logic [dspsc_pkg::NPORT-1:0] o_req_sent,
  output logic [dspsc_pkg::NPORT-1:0] o_resp_got
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_rx_frame[0] = '{1'b0, 8'hA5};
    o_rx_frame[1] = '{1'b0, 8'h5A};
    o_req_sent = '0;
    o_resp_got = '0;
  end
  ////////////////////////////////////////
  // Frame to a given station address
  task automatic send(input int p, input logic [7:0] a, input int gap);
    repeat (gap + 1) @(posedge i_core_clk);
    o_rx_frame[p] <= '{1'b1, a};
    @(posedge i_core_clk);
    o_rx_frame[p] <= '{1'b0, ~a};
  endtask
  // Request or reply pulse
  task automatic pulse(input int p, input bit is_resp, input int gap);
    repeat (gap + 1) @(posedge i_core_clk);
    if (is_resp) o_resp_got[p] <= 1'b1;
    else o_req_sent[p] <= 1'b1;
    @(posedge i_core_clk);
    o_resp_got[p] <= 1'b0;
    o_req_sent[p] <= 1'b0;
  endtask
endmodule

// ### bench/dspsc_tb.sv
// Purpose: Self-checking bench for the dual port configuration block
// Assumes: Tick shortened to TICK cycles
// Notes: Pulse outputs are stamped by a monitor
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 10;
  logic clk;
  logic rst;
  logic [6:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wreq;
  logic run;
  logic irq;
  logic [31:0] q;
  dspsc_pkg::dspsc_frame_type frame [dspsc_pkg::NPORT];
  logic [1:0] req;
  logic [1:0] resp;
  dspsc_pkg::dspsc_port_out_type port [dspsc_pkg::NPORT];
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  int acc_n [2];
  int acc_t [2];
  int go_n [2];
  int go_t [2];
  int tmo_n [2];
  int tmo_t [2];
  int req_t [2];

  dspsc_top #(.P_TICK_CYC(TICK)) dut (.i_core_clk(clk), .i_rst(rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_plc_run(run), .i_rx_frame(frame), .i_req_sent(req),
    .i_resp_got(resp), .o_port(port), .o_irq(irq));
  dspsc_remote_master rm (.i_core_clk(clk), .o_rx_frame(frame), .o_req_sent(req),
    .o_resp_got(resp));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    for (int p = 0; p < 2; p++) begin
      if (port[p].accept === 1'b1) begin
        acc_n[p]++;
        acc_t[p] = cyc;
      end
      if (port[p].reply_go === 1'b1) begin
        go_n[p]++;
        go_t[p] = cyc;
      end
      if (port[p].rx_timeout === 1'b1) begin
        tmo_n[p]++;
        tmo_t[p] = cyc;
      end
      if (req[p] === 1'b1) req_t[p] = cyc;
    end
  end
  ////////////////////////////////////////
  function automatic logic [6:0] pa(input int p, input logic [6:0] off);
    return off + 7'(32 * p);
  endfunction
  function automatic logic [31:0] fld(input int p);
    return 32'({port[p].data8, port[p].parity, port[p].stop2, port[p].rtu});
  endfunction
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  initial begin
    wait_cyc(20000);
    errors++;
    conclude;
  end
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    adr = '0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = '0;
    run = 1'b0;
    wait_cyc(8);
    rst <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      rd_chk(pa(p, dspsc_pkg::OFF_ADDR), 32'h0000_0001);
      rd_chk(pa(p, dspsc_pkg::OFF_CTRL), 32'h0000_0086);
      rd_chk(pa(p, dspsc_pkg::OFF_CUSTOM), 32'h0000_0060);
      rd_chk(pa(p, dspsc_pkg::OFF_DELAY), 32'h0000_0000);
      rd_chk(pa(p, dspsc_pkg::OFF_TMO), 32'h0000_00C8);
      chk(32'(port[p].rate), 32'h0000_0060);
      chk(fld(p), 32'h0000_0008);
    end
    bus(1'b1, pa(1, dspsc_pkg::OFF_ADDR), 32'h0000_0005);
    bus(1'b1, pa(1, dspsc_pkg::OFF_ADDR), 32'h0000_0000);
    bus(1'b1, pa(1, dspsc_pkg::OFF_ADDR), 32'h0000_00FF);
    rd_chk(pa(1, dspsc_pkg::OFF_ADDR), 32'h0000_0005);
    rd_chk(pa(0, dspsc_pkg::OFF_ADDR), 32'h0000_0001);
    bus(1'b1, 7'h3C, 32'hFFFF_FFFF);
    rd_chk(7'h3C, 32'h0000_0000);
    bus(1'b1, pa(0, dspsc_pkg::OFF_STATE), 32'h0000_0007);
    rd_chk(pa(0, dspsc_pkg::OFF_STATE), 32'h0000_0000);
    // Frame while stopped
    rm.send(0, 8'h01, 0);
    wait_cyc(3);
    chk(acc_n[0], 0);
    run <= 1'b1;
    wait_cyc(3);
    rd_chk(pa(0, dspsc_pkg::OFF_STATE), 32'h0000_0001);
    rm.send(0, dspsc_pkg::ADDR_BCAST, 2);
    wait_cyc(3);
    chk(acc_n[0], 1);
    chk(go_t[0] - acc_t[0], 1);
    rm.send(1, 8'h01, 0);
    wait_cyc(3);
    chk(acc_n[1], 0);
    rm.send(1, 8'h05, 0);
    wait_cyc(3);
    chk(acc_n[1], 1);
    // Reply delay of 2 ms
    bus(1'b1, pa(0, dspsc_pkg::OFF_DELAY), 32'h0000_0002);
    bus(1'b1, pa(0, dspsc_pkg::OFF_DELAY), 32'h0000_0BB9);
    rd_chk(pa(0, dspsc_pkg::OFF_DELAY), 32'h0000_0002);
    run <= 1'b0;
    wait_cyc(3);
    run <= 1'b1;
    wait_cyc(3);
    n = go_n[0];
    rm.send(0, 8'h01, 1);
    for (int i = 0; i < 100 && go_n[0] == n; i++) @(posedge clk);
    chk(go_t[0] - acc_t[0] >= 2 * TICK && go_t[0] - acc_t[0] <= 2 * TICK + 2, 1);
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, pa(0, dspsc_pkg::OFF_CTRL), 32'h0000_0080 | 32'(s << 1));
      wait_cyc(2);
      chk(32'(port[0].rate), 32'(dspsc_pkg::RATE_TAB[s]));
    end
    bus(1'b1, pa(0, dspsc_pkg::OFF_CUSTOM), 32'h0000_1388);
    bus(1'b1, pa(0, dspsc_pkg::OFF_CUSTOM), 32'h0000_1389);
    bus(1'b1, pa(0, dspsc_pkg::OFF_CUSTOM), 32'h0000_0000);
    bus(1'b1, pa(0, dspsc_pkg::OFF_CTRL), 32'h0000_0096);
    wait_cyc(2);
    chk(32'(port[0].rate), 32'h0000_1388);
    bus(1'b1, pa(0, dspsc_pkg::OFF_CTRL), 32'h0000_0366);
    wait_cyc(2);
    chk(fld(0), 32'h0000_0017);
    chk(fld(1), 32'h0000_0008);
    // Power-on port, receive timeout and interrupt
    run <= 1'b0;
    bus(1'b1, pa(1, dspsc_pkg::OFF_CTRL), 32'h0000_0087);
    bus(1'b1, pa(1, dspsc_pkg::OFF_TMO), 32'h0000_0003);
    bus(1'b1, dspsc_pkg::OFF_STATUS, 32'h0000_000F);
    rd_chk(pa(1, dspsc_pkg::OFF_STATE), 32'h0000_0001);
    rd_chk(dspsc_pkg::OFF_STATUS, 32'h0000_0000);
    n = tmo_n[1];
    rm.pulse(1, 1'b0, 0);
    rm.pulse(1, 1'b1, 5);
    wait_cyc(50);
    chk(tmo_n[1] - n, 0);
    // Zero timeout waits for the reply forever
    bus(1'b1, pa(1, dspsc_pkg::OFF_TMO), 32'h0000_0000);
    rm.pulse(1, 1'b0, 0);
    wait_cyc(50);
    chk(tmo_n[1] - n, 0);
    rd_chk(pa(1, dspsc_pkg::OFF_STATE), 32'h0000_0005);
    rm.pulse(1, 1'b1, 0);
    rd_chk(pa(1, dspsc_pkg::OFF_STATE), 32'h0000_0001);
    bus(1'b1, pa(1, dspsc_pkg::OFF_TMO), 32'h0000_0003);
    bus(1'b1, dspsc_pkg::OFF_MASK, 32'h0000_0008);
    chk(irq, 1'b0);
    for (int k = 0; k < 2; k++) begin
      n = tmo_n[1];
      rm.pulse(1, 1'b0, k);
      for (int i = 0; i < 100 && tmo_n[1] == n; i++) @(posedge clk);
      chk(tmo_t[1] - req_t[1] >= 3 * TICK && tmo_t[1] - req_t[1] <= 3 * TICK + 3, 1);
      wait_cyc(2);
      chk(irq, k == 0);
      rd_chk(dspsc_pkg::OFF_STATUS, 32'h0000_0008);
      bus(1'b1, k == 0 ? dspsc_pkg::OFF_STATUS : dspsc_pkg::OFF_MASK, 32'h0000_0008);
      wait_cyc(2);
      chk(irq, k == 1);
      if (k == 0) bus(1'b1, dspsc_pkg::OFF_MASK, 32'h0000_0000);
    end
    conclude;
  end
endmodule
